// *** hw/sas_top.sv ***
// Smoke alarm sequencer: wake timer, IR sampling, escalation, indication, AHB-Lite registers
`timescale 1ns/10ps
`include "sas_params.svh"

module sas_top #(
	parameter logic [27:0] WAKE_SLOW_CYC = 28'(`SAS_WAKE_SLOW_MS * `SAS_CYC_PER_MS),
	parameter logic [27:0] WAKE_FAST_CYC = 28'(`SAS_WAKE_FAST_MS * `SAS_CYC_PER_MS),
	parameter logic [27:0] FIRE_BUZZ_CYC = 28'(`SAS_FIRE_BUZZ_MS * `SAS_CYC_PER_MS),
	parameter logic [27:0] FIRE_FLASH_CYC = 28'(`SAS_FIRE_FLASH_MS * `SAS_CYC_PER_MS),
	parameter logic [27:0] POR_FLASH_CYC = 28'(`SAS_POR_FLASH_MS * `SAS_CYC_PER_MS),
	parameter logic [27:0] KEY_BEEP_CYC = 28'(`SAS_KEY_BEEP_MS * `SAS_CYC_PER_MS),
	parameter logic [27:0] LOWBAT_CYC = 28'(`SAS_LOWBAT_MS * `SAS_CYC_PER_MS)
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	// AHB-Lite slave
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	// Board inputs
	input wire logic [9:0] LIGHT_LEVEL_IN,
	input wire logic KEY_PRESSED_IN,
	input wire logic LOW_BATTERY_FLAG_N_IN,
	// Board outputs
	output logic IR_PULSE_OUT,
	output logic FIRST_ALARM_LED_OUT,
	output logic SECOND_ALARM_LED_OUT,
	output logic BUZZER_OUT,
	output sas_pkg::sas_mode_t SLEEP_MODE_OUT
);
	localparam logic [11:0] IR_CYC = 12'(`SAS_IR_PULSE_US * `SAS_CYC_PER_US);
	localparam logic [11:0] IR_SMP = IR_CYC >> 1;

	sas_pkg::sas_state_t st_q;
	sas_pkg::sas_ind_t ind_q, ind_sel;
	sas_pkg::sas_cfg_t cfg_q;
	sas_pkg::sas_status_t status;
	logic phase_q;
	logic [27:0] ind_cnt_q;
	logic [11:0] ir_cnt_q;
	logic [9:0] smp_q;
	logic smp_stb;
	logic [7:0] cnt_q;
	logic fast_q, fire_q, above, fire_set, fire_clr;
	logic [27:0] wake_cnt_q, wake_lim;
	logic wake_hit, wake_evt_q;
	logic bus_sel, wr_q;
	logic [7:0] waddr_q;
	logic low_batt;

	// Low level on the monitor line means a weak battery
	assign low_batt = !LOW_BATTERY_FLAG_N_IN;

	// Wake timer; counter is never stopped so the interval stays exact
	assign wake_lim = fast_q ? WAKE_FAST_CYC : WAKE_SLOW_CYC;
	assign wake_hit = (wake_cnt_q >= wake_lim - 28'h1);

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			wake_cnt_q <= 28'h0;
		end else if (wake_hit) begin
			wake_cnt_q <= 28'h0;
		end else begin
			wake_cnt_q <= wake_cnt_q + 28'h1;
		end
	end

	// Pending event; a new tick in the clearing cycle wins
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			wake_evt_q <= 1'b0;
		end else if (wake_hit) begin
			wake_evt_q <= 1'b1;
		end else if (st_q == sas_pkg::ST_IDLE && wake_evt_q) begin
			wake_evt_q <= 1'b0;
		end
	end

	// Sample taken mid-pulse so the emitter is surely lit
	assign smp_stb = (st_q == sas_pkg::ST_PULSE) && (ir_cnt_q == IR_SMP);

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			smp_q <= 10'h000;
		end else if (smp_stb) begin
			smp_q <= LIGHT_LEVEL_IN;
		end
	end

	// Escalation
	assign above = smp_q > cfg_q.thresh;
	assign fire_set = (st_q == sas_pkg::ST_EVAL) && above && (cnt_q >= cfg_q.limit);

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			cnt_q <= 8'h00;
			fast_q <= 1'b0;
		end else if (st_q == sas_pkg::ST_EVAL) begin
			if (above) begin
				fast_q <= 1'b1;
				if (cnt_q != 8'hFF) begin
					cnt_q <= cnt_q + 8'h01;
				end
			end else begin
				fast_q <= 1'b0;
				cnt_q <= 8'h00;
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			fire_q <= 1'b0;
		end else if (fire_set) begin
			fire_q <= 1'b1;
		end else if (fire_clr) begin
			fire_q <= 1'b0;
		end
	end

	// A fresh fire alarm outranks the battery warning, which outranks the key
	always_comb begin
		ind_sel = sas_pkg::IND_NONE;
		if (fire_set && !fire_q) begin
			ind_sel = sas_pkg::IND_FIRE;
		end else if (low_batt) begin
			ind_sel = sas_pkg::IND_LOWBAT;
		end else if (KEY_PRESSED_IN && !fire_q) begin
			ind_sel = sas_pkg::IND_KEY;
		end
	end

	// Sequencer
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			st_q <= sas_pkg::ST_POR;
			ind_q <= sas_pkg::IND_NONE;
			phase_q <= 1'b0;
			ind_cnt_q <= POR_FLASH_CYC;
			ir_cnt_q <= 12'h000;
		end else begin
			case (st_q)
				sas_pkg::ST_POR: begin
					if (ind_cnt_q == 28'h0) begin
						st_q <= sas_pkg::ST_IDLE;
					end else begin
						ind_cnt_q <= ind_cnt_q - 28'h1;
					end
				end
				sas_pkg::ST_IDLE: begin
					if (wake_evt_q) begin
						st_q <= sas_pkg::ST_PULSE;
						ir_cnt_q <= 12'h000;
					end
				end
				sas_pkg::ST_PULSE: begin
					if (ir_cnt_q == IR_CYC - 12'h001) begin
						st_q <= sas_pkg::ST_EVAL;
					end else begin
						ir_cnt_q <= ir_cnt_q + 12'h001;
					end
				end
				sas_pkg::ST_EVAL: begin
					ind_q <= ind_sel;
					phase_q <= 1'b0;
					case (ind_sel)
						sas_pkg::IND_FIRE: ind_cnt_q <= FIRE_FLASH_CYC;
						sas_pkg::IND_LOWBAT: ind_cnt_q <= LOWBAT_CYC;
						sas_pkg::IND_KEY: ind_cnt_q <= KEY_BEEP_CYC;
						default: ind_cnt_q <= 28'h0;
					endcase
					st_q <= (ind_sel == sas_pkg::IND_NONE) ? sas_pkg::ST_IDLE
						: sas_pkg::ST_IND;
				end
				sas_pkg::ST_IND: begin
					if (ind_cnt_q != 28'h0) begin
						ind_cnt_q <= ind_cnt_q - 28'h1;
					end else if (ind_q == sas_pkg::IND_FIRE && !phase_q) begin
						phase_q <= 1'b1;
						ind_cnt_q <= FIRE_BUZZ_CYC;
					end else begin
						st_q <= sas_pkg::ST_IDLE;
					end
				end
				default: st_q <= sas_pkg::ST_IDLE;
			endcase
		end
	end

	// Pin drivers, all registered
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			IR_PULSE_OUT <= 1'b0;
			FIRST_ALARM_LED_OUT <= 1'b0;
			SECOND_ALARM_LED_OUT <= 1'b0;
			BUZZER_OUT <= 1'b0;
			SLEEP_MODE_OUT <= sas_pkg::MODE_RUN;
		end else begin
			IR_PULSE_OUT <= (st_q == sas_pkg::ST_PULSE);
			FIRST_ALARM_LED_OUT <= (st_q == sas_pkg::ST_POR) || (st_q == sas_pkg::ST_IND
				&& (ind_q == sas_pkg::IND_LOWBAT || (ind_q == sas_pkg::IND_FIRE && !phase_q)));
			SECOND_ALARM_LED_OUT <= (st_q == sas_pkg::ST_POR)
				|| (st_q == sas_pkg::ST_IND && ind_q == sas_pkg::IND_LOWBAT);
			BUZZER_OUT <= (st_q == sas_pkg::ST_IND) && (ind_q == sas_pkg::IND_LOWBAT
				|| ind_q == sas_pkg::IND_KEY || (ind_q == sas_pkg::IND_FIRE && phase_q));
			// Stop halts more clocks; key or alarm keeps light sleep
			if (st_q != sas_pkg::ST_IDLE) begin
				SLEEP_MODE_OUT <= sas_pkg::MODE_RUN;
			end else if (KEY_PRESSED_IN || fire_q) begin
				SLEEP_MODE_OUT <= sas_pkg::MODE_SLEEP;
			end else begin
				SLEEP_MODE_OUT <= sas_pkg::MODE_STOP;
			end
		end
	end

	// Register bus: zero wait states, always OKAY
	assign bus_sel = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
	assign fire_clr = wr_q && (waddr_q == `SAS_OFS_CLEAR) && HWDATA_IN[`SAS_CLR_FIRE_BIT];
	assign status = '{rsvd: 10'h000, low_battery: low_batt, key: KEY_PRESSED_IN,
		fire: fire_q, fast: fast_q, count: cnt_q, sample: smp_q};

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			wr_q <= 1'b0;
			waddr_q <= 8'h00;
			HRDATA_OUT <= 32'h0000_0000;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT <= 1'b0;
		end else begin
			wr_q <= bus_sel && HWRITE_IN;
			waddr_q <= HADDR_IN[7:0];
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT <= 1'b0;
			if (bus_sel && !HWRITE_IN) begin
				case (HADDR_IN[7:0])
					`SAS_OFS_THRESH: HRDATA_OUT <= {22'h0, cfg_q.thresh};
					`SAS_OFS_LIMIT: HRDATA_OUT <= {24'h0, cfg_q.limit};
					`SAS_OFS_STATUS: HRDATA_OUT <= status;
					default: HRDATA_OUT <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			cfg_q <= '{thresh: `SAS_THRESH_RST, limit: `SAS_LIMIT_RST};
		end else if (wr_q && waddr_q == `SAS_OFS_THRESH) begin
			cfg_q.thresh <= HWDATA_IN[9:0];
		end else if (wr_q && waddr_q == `SAS_OFS_LIMIT) begin
			cfg_q.limit <= HWDATA_IN[7:0];
		end
	end

	// Checks
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);

	AST_POR_ONCE: assert property (st_q != sas_pkg::ST_POR |=> st_q != sas_pkg::ST_POR)
		else $error("power-up flash repeated");
	AST_KEY_BEEP: assert property (st_q == sas_pkg::ST_EVAL && ind_sel == sas_pkg::IND_KEY
		|-> ##2 BUZZER_OUT)
		else $error("key beep missing");
	AST_LOWBAT: assert property (st_q == sas_pkg::ST_IND && ind_q == sas_pkg::IND_LOWBAT
		|=> FIRST_ALARM_LED_OUT && SECOND_ALARM_LED_OUT && BUZZER_OUT)
		else $error("battery warning not simultaneous");
	AST_FIRE_ORDER: assert property (st_q == sas_pkg::ST_IND && ind_q == sas_pkg::IND_FIRE
		|=> FIRST_ALARM_LED_OUT != BUZZER_OUT)
		else $error("fire flash and buzzer overlap");
	AST_WAKE: assert property (wake_hit |=> wake_evt_q && wake_cnt_q == 28'h0)
		else $error("wake tick lost");
	AST_SAMPLE: assert property (smp_stb |-> IR_PULSE_OUT)
		else $error("sample outside pulse");
	AST_FAST: assert property (st_q == sas_pkg::ST_EVAL && above
		|=> fast_q && cnt_q != 8'h00)
		else $error("high sample not counted");
	AST_CLR_EVT: assert property (st_q == sas_pkg::ST_IDLE && wake_evt_q && !wake_hit
		|=> !wake_evt_q && st_q == sas_pkg::ST_PULSE ##1 IR_PULSE_OUT)
		else $error("event not cleared before pulse");
	AST_MODE: assert property (st_q == sas_pkg::ST_IDLE && !KEY_PRESSED_IN && !fire_q
		|=> SLEEP_MODE_OUT == sas_pkg::MODE_STOP)
		else $error("wrong low-power mode");
	AST_BELOW: assert property (st_q == sas_pkg::ST_EVAL && !above
		|=> cnt_q == 8'h00 && !fast_q)
		else $error("low sample did not reset");
	AST_FIRE_SET: assert property (st_q == sas_pkg::ST_EVAL && above && cnt_q >= cfg_q.limit
		|=> fire_q && fast_q)
		else $error("fire alarm not raised");

	COV_FIRE: cover property (st_q == sas_pkg::ST_IND && ind_q == sas_pkg::IND_FIRE && phase_q);
	COV_LOWBAT: cover property (st_q == sas_pkg::ST_IND && ind_q == sas_pkg::IND_LOWBAT);
	COV_KEY: cover property (st_q == sas_pkg::ST_IND && ind_q == sas_pkg::IND_KEY);
endmodule

// *** hw/sas_params.svh ***
// Offsets, field positions, reset values and timing figures of the alarm sequencer
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH
`define SAS_CLK_HZ 20000000
`define SAS_CYC_PER_MS (`SAS_CLK_HZ / 1000)
`define SAS_CYC_PER_US (`SAS_CLK_HZ / 1000000)
`define SAS_WAKE_SLOW_MS 4000
`define SAS_WAKE_FAST_MS 1000
`define SAS_FIRE_BUZZ_MS 11000
`define SAS_FIRE_FLASH_MS 500
`define SAS_POR_FLASH_MS 500
`define SAS_KEY_BEEP_MS 100
`define SAS_LOWBAT_MS 200
`define SAS_IR_PULSE_US 100
`define SAS_OFS_THRESH 8'h00
`define SAS_OFS_LIMIT 8'h04
`define SAS_OFS_STATUS 8'h08
`define SAS_OFS_CLEAR 8'h0C
`define SAS_CLR_FIRE_BIT 0
`define SAS_THRESH_RST 10'h200
`define SAS_LIMIT_RST 8'h03
`endif

// *** hw/sas_pkg.sv ***
// Types shared by the alarm sequencer
package sas_pkg;
	typedef enum logic [2:0] {ST_POR, ST_IDLE, ST_PULSE, ST_EVAL, ST_IND} sas_state_t;
	typedef enum logic [1:0] {IND_NONE, IND_KEY, IND_LOWBAT, IND_FIRE} sas_ind_t;
	typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_STOP} sas_mode_t;
	typedef struct packed {
		logic [9:0] rsvd;
		logic low_battery;
		logic key;
		logic fire;
		logic fast;
		logic [7:0] count;
		logic [9:0] sample;
	} sas_status_t;
	typedef struct packed {
		logic [9:0] thresh;
		logic [7:0] limit;
	} sas_cfg_t;
endpackage

// *** dv/sas_board.sv ***
// Board model: IR emitter and sensor, self-test key, battery monitor
`timescale 1ns/10ps
module sas_board (
	// Clock and emitter
	input wire logic clk_in,
	input wire logic ir_in,
	// Scene set by the bench
	input wire logic [9:0] smoke_in,
	input wire logic key_in,
	input wire logic lowbat_in,
	// Towards the sequencer
	output logic [9:0] light_out,
	output logic key_out,
	output logic low_battery_flag_n_out
);
	logic [9:0] junk_q = 10'h155;
	always_ff @(posedge clk_in) begin
		junk_q <= junk_q + 10'h1F3;
	end
	// No reflection without the emitter, so a stray sample reads noise
	assign light_out = ir_in ? smoke_in : junk_q;
	assign key_out = key_in;
	assign low_battery_flag_n_out = ~lowbat_in;
endmodule

// *** dv/sas_top_tb.sv ***
// Self-checking bench for the alarm sequencer
`timescale 1ns/10ps
module sas_top_tb;
	localparam logic [27:0] SLOW = 28'hFA0;
	// Fast interval outlasts pulse plus fire flash and buzz, so no tick waits on it
	localparam logic [27:0] FAST = 28'hA28;
	localparam logic [27:0] BUZZ = 28'h12C;
	localparam logic [27:0] FLASH = 28'hC8;
	localparam logic [27:0] KEYB = 28'h64;
	localparam logic [27:0] LOWB = 28'h96;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready, hresp, ir, led1, led2, buz, key, lbn;
	logic key_r = 1'b0;
	logic lowbat = 1'b0;
	logic rd_ph = 1'b0;
	logic [9:0] light;
	logic [9:0] smoke = 10'h0;
	logic [9:0] thr;
	logic [2:0] outs;
	sas_pkg::sas_mode_t mode;
	logic [31:0] rd_q[$];
	logic [31:0] pw_q[$];
	int len[3];
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	int t0, t1;
	always #25 clk = ~clk;
	assign outs = {buz, led2, led1};
	sas_board board (.clk_in(clk), .ir_in(ir), .smoke_in(smoke), .key_in(key_r),
		.lowbat_in(lowbat), .light_out(light), .key_out(key), .low_battery_flag_n_out(lbn));
	sas_top #(.WAKE_SLOW_CYC(SLOW), .WAKE_FAST_CYC(FAST), .FIRE_BUZZ_CYC(BUZZ),
		.FIRE_FLASH_CYC(FLASH), .POR_FLASH_CYC(FLASH), .KEY_BEEP_CYC(KEYB),
		.LOWBAT_CYC(LOWB)) dut (.CLK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(hsel),
		.HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
		.HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
		.HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .LIGHT_LEVEL_IN(light),
		.KEY_PRESSED_IN(key), .LOW_BATTERY_FLAG_N_IN(lbn), .IR_PULSE_OUT(ir),
		.FIRST_ALARM_LED_OUT(led1), .SECOND_ALARM_LED_OUT(led2), .BUZZER_OUT(buz),
		.SLEEP_MODE_OUT(mode));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		chk(32'(pw_q.size()), 32'h0);
		$display("Checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch = n_mismatch + 1;
			wrap_up();
		end
	end
	// Monitor: read data at data-phase end, pulse lengths as they end
	always @(posedge clk) begin
		if (rd_ph && hready === 1'b1) begin
			chk(hrdata, rd_q.pop_front());
			chk({31'h0, hresp}, 32'h0);
		end
		foreach (len[i]) begin
			if (outs[i] === 1'b1) begin
				len[i] = len[i] + 1;
			end else if (len[i] != 0) begin
				chk({4'(i), 28'(len[i])}, pw_q.size() ? pw_q.pop_front() : 32'hFFFFFFFF);
				len[i] = 0;
			end
		end
	end
	// Read passes its expectation in d
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= ~wr;
		if (!wr) rd_q.push_back(d);
		do @(posedge clk); while (hready !== 1'b1);
		rd_ph <= 1'b0;
	endtask
	task automatic ir_rise(output int t);
		@(posedge clk iff ir === 1'b0);
		@(posedge clk iff ir === 1'b1);
		t = cyc;
	endtask
	task automatic st(input logic [31:0] e);
		@(posedge clk iff ir === 1'b0);
		repeat (4) @(posedge clk);
		bus(1'b0, 8'h08, e);
	endtask
	initial begin
		void'($urandom(62679));
		thr = 10'(($urandom % 768) + 128);
		pw_q.push_back({4'h0, 28'(FLASH + 1)});
		pw_q.push_back({4'h1, 28'(FLASH + 1)});
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		bus(1'b0, 8'h00, 32'h200);
		bus(1'b0, 8'h04, 32'h3);
		bus(1'b0, 8'h10, 32'h0);
		bus(1'b1, 8'h00, {22'h0, thr});
		bus(1'b1, 8'h04, 32'h1);
		bus(1'b0, 8'h00, {22'h0, thr});
		// Equal to threshold must still count as clear air
		smoke <= thr;
		$display("Test registers done");
		ir_rise(t0);
		@(posedge clk iff ir === 1'b0);
		chk(32'(cyc - t0), 32'h7D0);
		ir_rise(t1);
		chk(32'(t1 - t0), 32'(SLOW));
		st({22'h0, thr});
		$display("Test idle wake done");
		key_r <= 1'b1;
		repeat (2) begin
			pw_q.push_back({4'h2, 28'(KEYB + 1)});
			@(posedge clk iff buz === 1'b1);
			@(posedge clk iff buz === 1'b0);
			repeat (3) @(posedge clk);
			chk(32'(mode), 32'(sas_pkg::MODE_SLEEP));
		end
		key_r <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(mode), 32'(sas_pkg::MODE_STOP));
		$display("Test key done");
		lowbat <= 1'b1;
		foreach (len[i]) pw_q.push_back({4'(i), 28'(LOWB + 1)});
		@(posedge clk iff buz === 1'b1);
		@(posedge clk iff buz === 1'b0);
		lowbat <= 1'b0;
		$display("Test low battery done");
		smoke <= thr + 10'h1;
		ir_rise(t0);
		st({14'h1, 8'h1, thr + 10'h1});
		pw_q.push_back({4'h0, 28'(FLASH + 1)});
		pw_q.push_back({4'h2, 28'(BUZZ + 1)});
		ir_rise(t1);
		chk(32'(t1 - t0), 32'(FAST));
		@(posedge clk iff led1 === 1'b1);
		smoke <= thr;
		bus(1'b0, 8'h08, {12'h0, 2'h3, 8'h2, thr + 10'h1});
		ir_rise(t0);
		chk(32'(t0 - t1), 32'(FAST));
		st({12'h0, 2'h2, 8'h0, thr});
		bus(1'b1, 8'h0C, 32'h1);
		bus(1'b0, 8'h08, {22'h0, thr});
		ir_rise(t1);
		chk(32'(t1 - t0), 32'(SLOW));
		$display("Test fire done");
		wrap_up();
	end
endmodule
